//--- rtl/esfb_event_bank.sv
// event status flag bank with summary register and register port
//
// Contract
// [RULE1] writing one clears a flag, zero leaves it; host clears after identifying
// [RULE2] summary bit 3 is set while any wake pin flag pends
// [RULE3] summary bit 2 is set while any transceiver flag pends
// [RULE4] summary bit 1 is set while any supply flag pends
// [RULE5] summary bit 0 is set while any system flag pends
// [RULE6] battery start-up flag sets on leaving off mode after power-on
// [RULE7] overheat warning flag sets above threshold, never in sleep mode
// [RULE8] serial fault flag sets on clock count other than 16, 24, 32
// [RULE9] serial fault also for illegal codes and locked writes, not in sleep
// [RULE10] watchdog fault sets on overflow or early trigger in window mode
// [RULE11] window mode watchdog failure asserts system reset immediately
// [RULE12] timeout mode overflow resets only if watchdog flag already set
// [RULE13] supply bit 2 sets on second regulator or external overvoltage
// [RULE14] supply bit 1 sets on second regulator or external undervoltage
// [RULE15] main supply undervoltage flag sets while supply active, never in sleep
// [RULE16] main undervoltage capture ignores the reset threshold select bits
// [RULE17] transceiver bit 5 sets on selective frame decode error
// [RULE18] bus silence flag sets after timeout, only if enabled while bus active
// [RULE19] a flag sets only while its capture enable is set
// [RULE20] start-up, watchdog and frame decode events are always captured; the code captures watchdog events only in window or timeout mode
// [RULE21] reserved bits read zero; summary bits are ORs of their registers
module esfb_event_bank
  import esfb_pkg::*;
#(
  parameter int unsigned SILENCE_CYC = ESFB_SILENCE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // register port
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rd_valid,
  // mode status
  input  wire logic        sleep_mode,
  input  wire logic        wdog_window_mode,
  input  wire logic        wdog_timeout_mode,
  input  wire logic        main_supply_active,
  // capture enables
  input  wire logic        overheat_capture_enable,
  input  wire logic        serial_fault_capture_enable,
  input  wire logic        overvoltage_capture_enable,
  input  wire logic        undervoltage_capture_enable,
  input  wire logic        main_uv_capture_enable,
  input  wire logic        bus_silence_capture_enable,
  // event inputs, one-cycle pulses; serial_bit_count is a count and bus_active a level
  input  wire logic        battery_startup_evt,
  input  wire logic        overheat_evt,
  input  wire logic        serial_access_done,
  input  wire logic [5:0]  serial_bit_count,
  input  wire logic        watchdog_mode_code_illegal,
  input  wire logic        watchdog_period_code_illegal,
  input  wire logic        operating_mode_code_illegal,
  input  wire logic        locked_write_evt,
  input  wire logic        wdog_overflow_evt,
  input  wire logic        wdog_early_evt,
  input  wire logic        regulator_overvoltage_evt,
  input  wire logic        regulator_undervoltage_evt,
  input  wire logic        main_undervoltage_evt,
  input  wire logic        frame_decode_error_evt,
  input  wire logic        bus_active,
  // flags kept outside this bank
  input  wire logic [1:0]  trx_ext_flags,
  input  wire logic [1:0]  wake_pin_flags,
  // flag outputs
  output logic             battery_startup_flag,
  output logic             overheat_warning_flag,
  output logic             serial_port_fault_flag,
  output logic             watchdog_fault_flag,
  output logic             second_regulator_overvoltage_flag,
  output logic             second_regulator_undervoltage_flag,
  output logic             main_supply_undervoltage_flag,
  output logic             selective_frame_decode_error_flag,
  output logic             bus_silence_flag,
  output logic             system_pending,
  output logic             supply_pending,
  output logic             transceiver_pending,
  output logic             wake_pin_pending,
  output logic             system_reset_req
);

  logic [7:0] sys_q;
  logic [7:0] sys_d;
  logic [7:0] sup_q;
  logic [7:0] sup_d;
  logic [7:0] trx_q;
  logic [7:0] trx_d;
  logic [7:0] sys_set;
  logic [7:0] sup_set;
  logic [7:0] trx_set;
  logic [7:0] sys_clr;
  logic [7:0] sup_clr;
  logic [7:0] trx_clr;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;
  logic       rst_req_q;
  logic       rst_req_d;
  logic       silence_evt;
  logic       bad_length;
  logic       serial_fault_evt;
  logic [7:0] trx_view;
  logic [7:0] wake_view;
  logic [7:0] summary;

  // bus silence detection
  esfb_silence_timer #(
    .TIMEOUT_CYC (SILENCE_CYC),
    .CNT_W       (ESFB_SIL_CNT_W)
  ) u_silence (
    .ref_clk                    (ref_clk),
    .nrst                       (nrst),
    .clk_en                     (clk_en),
    .bus_active                 (bus_active),
    .bus_silence_capture_enable (bus_silence_capture_enable),
    .silence_evt                (silence_evt)
  );

  // [RULE8] legal lengths 16, 24, 32
  assign bad_length = serial_access_done &&
                      (serial_bit_count != ESFB_SPI_LEN16) &&
                      (serial_bit_count != ESFB_SPI_LEN24) &&
                      (serial_bit_count != ESFB_SPI_LEN32);

  // [RULE9] illegal codes and locked writes
  assign serial_fault_evt = bad_length || watchdog_mode_code_illegal ||
                            watchdog_period_code_illegal ||
                            operating_mode_code_illegal || locked_write_evt;

  // event set vectors
  always_comb begin
    sys_set = '0;
    sup_set = '0;
    trx_set = '0;
    // [RULE6] [RULE20] start-up always captured
    sys_set[ESFB_SYS_BATT_BIT] = battery_startup_evt;
    // [RULE7] [RULE19] gated, blocked in sleep
    sys_set[ESFB_SYS_HEAT_BIT] = overheat_evt && overheat_capture_enable && !sleep_mode;
    // [RULE9] [RULE19] gated, blocked in sleep
    sys_set[ESFB_SYS_SPI_BIT]  = serial_fault_evt && serial_fault_capture_enable &&
                                 !sleep_mode;
    // [RULE10] [RULE20] watchdog captured without enable, only in window or timeout mode
    sys_set[ESFB_SYS_WDOG_BIT] = (wdog_overflow_evt &&
                                  (wdog_window_mode || wdog_timeout_mode)) ||
                                 (wdog_early_evt && wdog_window_mode);
    // [RULE13] [RULE19] overvoltage gated
    sup_set[ESFB_SUP_OV_BIT]   = regulator_overvoltage_evt && overvoltage_capture_enable;
    // [RULE14] [RULE19] undervoltage gated
    sup_set[ESFB_SUP_UV_BIT]   = regulator_undervoltage_evt && undervoltage_capture_enable;
    // [RULE15] [RULE16] active supply only, no threshold term
    sup_set[ESFB_SUP_MAINUV_BIT] = main_undervoltage_evt && main_uv_capture_enable &&
                                   main_supply_active && !sleep_mode;
    // [RULE17] [RULE20] decode error always captured
    trx_set[ESFB_TRX_PNFD_BIT] = frame_decode_error_evt;
    // [RULE18] [RULE19] silence from armed detector
    trx_set[ESFB_TRX_SIL_BIT]  = silence_evt;
  end

  // [RULE1] write one to clear
  always_comb begin
    sys_clr = '0;
    sup_clr = '0;
    trx_clr = '0;
    if (reg_wr_en) begin
      unique case (reg_addr)
        ESFB_OFS_SYSTEM: sys_clr = reg_wdata;
        ESFB_OFS_SUPPLY: sup_clr = reg_wdata;
        ESFB_OFS_TRX:    trx_clr = reg_wdata;
        default: begin
          sys_clr = '0;
        end
      endcase
    end
  end

  // [RULE1] [RULE21] set wins, reserved masked
  always_comb begin
    sys_d = ((sys_q & ~sys_clr) | sys_set) & ESFB_SYS_MASK;
    sup_d = ((sup_q & ~sup_clr) | sup_set) & ESFB_SUP_MASK;
    trx_d = ((trx_q & ~trx_clr) | trx_set) & ESFB_TRX_OWN;
  end

  // system reset request from watchdog
  always_comb begin
    rst_req_d = 1'b0;
    // [RULE11] window failure resets at once
    if (wdog_window_mode && (wdog_overflow_evt || wdog_early_evt)) begin
      rst_req_d = 1'b1;
    end
    // [RULE12] timeout overflow needs prior flag
    if (wdog_timeout_mode && wdog_overflow_evt && sys_q[ESFB_SYS_WDOG_BIT]) begin
      rst_req_d = 1'b1;
    end
  end

  // [RULE21] read views with external bits
  assign trx_view  = trx_q | ({6'h00, trx_ext_flags} & ESFB_TRX_EXT);
  assign wake_view = {6'h00, wake_pin_flags} & ESFB_WAKE_MASK;

  // [RULE2] [RULE3] [RULE4] [RULE5] [RULE21] summary ORs
  always_comb begin
    summary = '0;
    summary[ESFB_SUM_SYSTEM_BIT] = |sys_q;
    summary[ESFB_SUM_SUPPLY_BIT] = |sup_q;
    summary[ESFB_SUM_TRX_BIT]    = |trx_view;
    summary[ESFB_SUM_WAKE_BIT]   = |wake_view;
  end

  // read data path
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (reg_rd_en) begin
      rvalid_d = 1'b1;
      unique case (reg_addr)
        ESFB_OFS_SUMMARY: rdata_d = summary;
        ESFB_OFS_SYSTEM:  rdata_d = sys_q;
        ESFB_OFS_SUPPLY:  rdata_d = sup_q;
        ESFB_OFS_TRX:     rdata_d = trx_view;
        ESFB_OFS_WAKE:    rdata_d = wake_view;
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // flag registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sys_q <= ESFB_RST_FLAGS;
      sup_q <= ESFB_RST_FLAGS;
      trx_q <= ESFB_RST_FLAGS;
    end else if (clk_en) begin
      sys_q <= sys_d;
      sup_q <= sup_d;
      trx_q <= trx_d;
    end
  end

  // read port registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q  <= ESFB_RST_FLAGS;
      rvalid_q <= 1'b0;
    end else if (clk_en) begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // watchdog reset request register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rst_req_q <= 1'b0;
    end else if (clk_en) begin
      rst_req_q <= rst_req_d;
    end
  end

  assign reg_rdata                          = rdata_q;
  assign reg_rd_valid                       = rvalid_q;
  assign system_reset_req                   = rst_req_q;
  assign battery_startup_flag               = sys_q[ESFB_SYS_BATT_BIT];
  assign overheat_warning_flag              = sys_q[ESFB_SYS_HEAT_BIT];
  assign serial_port_fault_flag             = sys_q[ESFB_SYS_SPI_BIT];
  assign watchdog_fault_flag                = sys_q[ESFB_SYS_WDOG_BIT];
  assign second_regulator_overvoltage_flag  = sup_q[ESFB_SUP_OV_BIT];
  assign second_regulator_undervoltage_flag = sup_q[ESFB_SUP_UV_BIT];
  assign main_supply_undervoltage_flag      = sup_q[ESFB_SUP_MAINUV_BIT];
  assign selective_frame_decode_error_flag  = trx_q[ESFB_TRX_PNFD_BIT];
  assign bus_silence_flag                   = trx_q[ESFB_TRX_SIL_BIT];
  assign system_pending                     = summary[ESFB_SUM_SYSTEM_BIT];
  assign supply_pending                     = summary[ESFB_SUM_SUPPLY_BIT];
  assign transceiver_pending                = summary[ESFB_SUM_TRX_BIT];
  assign wake_pin_pending                   = summary[ESFB_SUM_WAKE_BIT];

endmodule : esfb_event_bank

//--- rtl/esfb_pkg.sv
// constants for the event status flag bank
package esfb_pkg;

  localparam int unsigned ESFB_ADDR_W    = 7;
  localparam int unsigned ESFB_DATA_W    = 8;

  // register offsets
  localparam logic [6:0] ESFB_OFS_SUMMARY = 7'h60;
  localparam logic [6:0] ESFB_OFS_SYSTEM  = 7'h61;
  localparam logic [6:0] ESFB_OFS_SUPPLY  = 7'h62;
  localparam logic [6:0] ESFB_OFS_TRX     = 7'h63;
  localparam logic [6:0] ESFB_OFS_WAKE    = 7'h64;

  // summary register fields
  localparam int unsigned ESFB_SUM_SYSTEM_BIT = 0;
  localparam int unsigned ESFB_SUM_SUPPLY_BIT = 1;
  localparam int unsigned ESFB_SUM_TRX_BIT    = 2;
  localparam int unsigned ESFB_SUM_WAKE_BIT   = 3;

  // system event register fields
  localparam int unsigned ESFB_SYS_WDOG_BIT   = 0;
  localparam int unsigned ESFB_SYS_SPI_BIT    = 1;
  localparam int unsigned ESFB_SYS_HEAT_BIT   = 2;
  localparam int unsigned ESFB_SYS_BATT_BIT   = 4;

  // supply event register fields
  localparam int unsigned ESFB_SUP_MAINUV_BIT = 0;
  localparam int unsigned ESFB_SUP_UV_BIT     = 1;
  localparam int unsigned ESFB_SUP_OV_BIT     = 2;

  // transceiver event register fields
  localparam int unsigned ESFB_TRX_WAKE_BIT   = 0;
  localparam int unsigned ESFB_TRX_FAIL_BIT   = 1;
  localparam int unsigned ESFB_TRX_SIL_BIT    = 4;
  localparam int unsigned ESFB_TRX_PNFD_BIT   = 5;

  // implemented bits per register, others read zero
  localparam logic [7:0] ESFB_SYS_MASK  = 8'h17;
  localparam logic [7:0] ESFB_SUP_MASK  = 8'h07;
  localparam logic [7:0] ESFB_TRX_OWN   = 8'h30;
  localparam logic [7:0] ESFB_TRX_EXT   = 8'h03;
  localparam logic [7:0] ESFB_WAKE_MASK = 8'h03;

  // reset values
  localparam logic [7:0] ESFB_RST_FLAGS = 8'h00;

  // legal serial clock counts
  localparam logic [5:0] ESFB_SPI_LEN16 = 6'h10;
  localparam logic [5:0] ESFB_SPI_LEN24 = 6'h18;
  localparam logic [5:0] ESFB_SPI_LEN32 = 6'h20;

  // bus silence timeout
  localparam int unsigned ESFB_CLK_HZ      = 100_000_000;
  localparam int unsigned ESFB_SILENCE_US  = 1000;
  localparam int unsigned ESFB_SILENCE_CYC =
    (ESFB_SILENCE_US * (ESFB_CLK_HZ / 1_000_000) > 0) ?
    ESFB_SILENCE_US * (ESFB_CLK_HZ / 1_000_000) : 1;
  localparam int unsigned ESFB_SIL_CNT_W   = 20;

  // silence detector states
  typedef enum logic [2:0] {
    ESFB_SIL_IDLE  = 3'b001,
    ESFB_SIL_ARMED = 3'b010,
    ESFB_SIL_COUNT = 3'b100
  } esfb_sil_state_t;

endpackage : esfb_pkg

//--- rtl/esfb_silence_timer.sv
// bus silence detector with arming and timeout
module esfb_silence_timer
  import esfb_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = ESFB_SILENCE_CYC,
  parameter int unsigned CNT_W       = ESFB_SIL_CNT_W
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic bus_active,
  input  wire logic bus_silence_capture_enable,
  output logic      silence_evt
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(TIMEOUT_CYC - 1);

  esfb_sil_state_t  state_q;
  esfb_sil_state_t  state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             evt_q;
  logic             evt_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    evt_d   = 1'b0;
    unique case (state_q)
      ESFB_SIL_IDLE: begin
        // [RULE18] arm only while bus active
        if (bus_silence_capture_enable && bus_active) begin
          state_d = ESFB_SIL_ARMED;
        end
      end
      ESFB_SIL_ARMED: begin
        cnt_d = '0;
        if (!bus_silence_capture_enable) begin
          state_d = ESFB_SIL_IDLE;
        end else if (!bus_active) begin
          state_d = ESFB_SIL_COUNT;
        end
      end
      ESFB_SIL_COUNT: begin
        if (!bus_silence_capture_enable) begin
          state_d = ESFB_SIL_IDLE;
        end else if (bus_active) begin
          state_d = ESFB_SIL_ARMED;
        end else if (cnt_q == LAST) begin
          // [RULE18] silence timeout reached
          evt_d   = 1'b1;
          state_d = ESFB_SIL_IDLE;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      default: begin
        state_d = ESFB_SIL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= ESFB_SIL_IDLE;
      cnt_q   <= '0;
      evt_q   <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      evt_q   <= evt_d;
    end
  end

  assign silence_evt = evt_q;

endmodule : esfb_silence_timer

//--- tb/esfb_checker.sv
// assertions on the event status flag bank ports
module esfb_checker
  import esfb_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic       sleep_mode,
  input wire logic       wdog_window_mode,
  input wire logic       wdog_timeout_mode,
  input wire logic       battery_startup_evt,
  input wire logic       wdog_overflow_evt,
  input wire logic       wdog_early_evt,
  input wire logic       frame_decode_error_evt,
  input wire logic [1:0] wake_pin_flags,
  input wire logic       battery_startup_flag,
  input wire logic       overheat_warning_flag,
  input wire logic       serial_port_fault_flag,
  input wire logic       watchdog_fault_flag,
  input wire logic       selective_frame_decode_error_flag,
  input wire logic       system_pending,
  input wire logic       wake_pin_pending,
  input wire logic       system_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic sys_clr;
  assign sys_clr = reg_wr_en && reg_addr == ESFB_OFS_SYSTEM && reg_wdata[ESFB_SYS_BATT_BIT];

  chk_wake_pend: assert property (wake_pin_pending == (|wake_pin_flags))
    else $error("wake pending differs from wake flags");
  chk_sys_pend: assert property (system_pending == (battery_startup_flag
      || overheat_warning_flag || serial_port_fault_flag || watchdog_fault_flag))
    else $error("system pending differs from system flags");
  chk_batt_set: assert property (clk_en && battery_startup_evt |=> battery_startup_flag)
    else $error("start-up event not captured");
  chk_frame_set: assert property (clk_en && frame_decode_error_evt
      |=> selective_frame_decode_error_flag)
    else $error("frame decode error not captured");
  chk_clear_one: assert property (clk_en && sys_clr && !battery_startup_evt
      |=> !battery_startup_flag)
    else $error("write of one did not clear");
  chk_keep_zero: assert property (clk_en && battery_startup_flag && !sys_clr
      |-> ##1 battery_startup_flag)
    else $error("flag lost without a clearing write");
  chk_win_reset: assert property (clk_en && wdog_window_mode
      && (wdog_overflow_evt || wdog_early_evt) |=> system_reset_req && watchdog_fault_flag)
    else $error("window failure gave no reset");
  chk_tmo_first: assert property (clk_en && wdog_timeout_mode && !wdog_window_mode
      && wdog_overflow_evt && !watchdog_fault_flag |=> !system_reset_req)
    else $error("first timeout overflow gave reset");
  chk_heat_sleep: assert property (clk_en && sleep_mode && !overheat_warning_flag
      |=> !overheat_warning_flag)
    else $error("overheat flag set in sleep");
  cover property (system_reset_req);
  cover property (battery_startup_flag && sys_clr);
  cover property (wake_pin_pending && system_pending);
endmodule // esfb_checker

bind esfb_event_bank esfb_checker i_chk (.*);

//--- tb/esfb_host.sv
// host model driving the register port
module esfb_host
  import esfb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid,
  output logic      [6:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 7'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
  end
  // released lines show the inverse of the last value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    d = reg_rdata;
    v = reg_rd_valid;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
  endtask
  task automatic ack(input logic [6:0] a, output logic [7:0] d);
    logic v;
    rd(a, d, v);
    wr(a, d);
  endtask
endmodule // esfb_host

//--- tb/esfb_event_bank_bench.sv
// self-checking bench for the event status flag bank
module esfb_event_bank_bench import esfb_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, bus_active = 1'b0;
  logic        sleep_mode = 1'b0, wdog_window_mode = 1'b0, wdog_timeout_mode = 1'b0;
  logic        main_supply_active = 1'b0;
  logic [5:0]  en = 6'h00, serial_bit_count = 6'h00;
  logic [1:0]  trx_ext_flags = 2'h0, wake_pin_flags = 2'h0;
  logic [12:0] ev = 13'h0000;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        reg_wr_en, reg_rd_en, reg_rd_valid, system_reset_req, bus_silence_flag;
  logic        battery_startup_flag, overheat_warning_flag, serial_port_fault_flag;
  logic        watchdog_fault_flag, second_regulator_overvoltage_flag, supply_pending;
  logic        second_regulator_undervoltage_flag, main_supply_undervoltage_flag;
  logic        selective_frame_decode_error_flag, system_pending, wake_pin_pending;
  logic        transceiver_pending;
  int          n_errors = 0, checks = 0, m_sys = 0, m_sup = 0, m_trx = 0;

  esfb_event_bank #(.SILENCE_CYC(8)) i_dut (
    .*,
    .overheat_capture_enable(en[0]), .serial_fault_capture_enable(en[1]),
    .overvoltage_capture_enable(en[2]), .undervoltage_capture_enable(en[3]),
    .main_uv_capture_enable(en[4]), .bus_silence_capture_enable(en[5]),
    .battery_startup_evt(ev[0]), .overheat_evt(ev[1]), .watchdog_mode_code_illegal(ev[2]),
    .watchdog_period_code_illegal(ev[3]), .operating_mode_code_illegal(ev[4]),
    .locked_write_evt(ev[5]), .wdog_overflow_evt(ev[6]), .wdog_early_evt(ev[7]),
    .regulator_overvoltage_evt(ev[8]), .regulator_undervoltage_evt(ev[9]),
    .main_undervoltage_evt(ev[10]), .frame_decode_error_evt(ev[11]),
    .serial_access_done(ev[12])
  );
  esfb_host i_host (.*);

  always #5 ref_clk = ~ref_clk;

  task automatic cmp(input string n, input int e, input logic [7:0] g);
    checks++;
    if (g !== 8'(e)) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, 8'(e), g);
    end
  endtask

  function automatic int expv(input int a);
    case (a)
      'h60: return {wake_pin_flags != 0, (m_trx | trx_ext_flags) != 0, m_sup != 0, m_sys != 0};
      'h61: return m_sys;
      'h62: return m_sup;
      'h63: return m_trx | trx_ext_flags;
      'h64: return wake_pin_flags;
      default: return 0;
    endcase
  endfunction

  task automatic chk_regs();
    logic [7:0] d;
    logic       v;
    cmp("pending ports", expv('h60), {wake_pin_pending, transceiver_pending,
        supply_pending, system_pending});
    cmp("system flags", m_sys, {battery_startup_flag, 1'b0,
        overheat_warning_flag, serial_port_fault_flag, watchdog_fault_flag});
    cmp("supply flags", m_sup, {second_regulator_overvoltage_flag,
        second_regulator_undervoltage_flag, main_supply_undervoltage_flag});
    cmp("trx flags", m_trx,
        {selective_frame_decode_error_flag, bus_silence_flag, 4'h0});
    for (int a = 'h60; a < 'h66; a++) begin
      i_host.rd(7'(a), d, v);
      cmp("read valid", 1, v);
      cmp($sformatf("register %h", a), expv(a), d);
    end
  endtask

  task automatic fire(input int i);
    int c;
    int r;
    c = (i == 12 && $urandom % 2) ? 16 + 8 * ($urandom % 3) : $urandom % 64;
    r = clk_en && (wdog_window_mode && (i == 6 || i == 7) ||
                   wdog_timeout_mode && i == 6 && m_sys[0]);
    @(negedge ref_clk);
    serial_bit_count = 6'(c);
    ev[i] = 1'b1;
    @(negedge ref_clk);
    ev[i] = 1'b0;
    cmp("reset request", r, system_reset_req);
    // capture gating, nothing taken while clock enable low
    if (clk_en) begin
      case (i)
        0: m_sys |= 16;
        1: if (en[0] && !sleep_mode) m_sys |= 4;
        2, 3, 4, 5: if (en[1] && !sleep_mode) m_sys |= 2;
        6: if (wdog_window_mode || wdog_timeout_mode) m_sys |= 1;
        7: if (wdog_window_mode) m_sys |= 1;
        8: if (en[2]) m_sup |= 4;
        9: if (en[3]) m_sup |= 2;
        10: if (en[4] && main_supply_active && !sleep_mode) m_sup |= 1;
        11: m_trx |= 32;
        default: if (c != 16 && c != 24 && c != 32 && en[1] && !sleep_mode) m_sys |= 2;
      endcase
    end
    clk_en = 1'b1;
  endtask

  task automatic silence(input logic e);
    @(negedge ref_clk);
    en[5] = e;
    bus_active = 1'b1;
    repeat (3) @(negedge ref_clk);
    bus_active = 1'b0;
    repeat (4) @(negedge ref_clk);
    cmp("silence early", 0, bus_silence_flag);
    repeat (8) @(negedge ref_clk);
    if (e) m_trx |= 16;
    chk_regs();
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial begin
    int         a;
    logic [7:0] d;
    logic [6:0] wa;
    void'($urandom(71366));
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
    chk_regs();
    $display("test reset values done");
    for (int k = 0; k < 150; k++) begin
      @(negedge ref_clk);
      {en, sleep_mode, main_supply_active, trx_ext_flags, wake_pin_flags} = 12'($urandom);
      clk_en = ($urandom % 4) != 0;
      a = $urandom % 3;
      wdog_window_mode = (a == 1);
      wdog_timeout_mode = (a == 2);
      fire($urandom % 13);
      chk_regs();
      wa = 7'(8'h60 + $urandom % 6);
      d = 8'($urandom);
      if (k % 2) i_host.ack(wa, d);
      else i_host.wr(wa, d);
      case (wa)
        ESFB_OFS_SYSTEM: m_sys &= ~int'(d);
        ESFB_OFS_SUPPLY: m_sup &= ~int'(d);
        ESFB_OFS_TRX: m_trx &= ~int'(d);
        default: ;
      endcase
    end
    $display("test random events done");
    silence(1'b0);
    silence(1'b1);
    $display("test bus silence done");
    finish_test();
  end
endmodule // esfb_event_bank_bench
